/* core/bcr_regs.svh */
// Register offsets, field positions and reset values of the converter control bank
`ifndef BCR_REGS_SVH
`define BCR_REGS_SVH
`define BCR_IDX_DEV 3'h0
`define BCR_IDX_MEM 3'h1
`define BCR_IDX_A1 3'h2
`define BCR_IDX_A2 3'h3
`define BCR_IDX_B1 3'h4
`define BCR_DEV_HI 5
`define BCR_DEV_LO 3
`define BCR_MEM_HI 7
`define BCR_MEM_LO 2
`define BCR_REV_HI 1
`define BCR_REV_LO 0
`define BCR_FIXED 4
`define BCR_DIS 3
`define BCR_GATE_HI 2
`define BCR_GATE_LO 1
`define BCR_EN 0
`define BCR_ILIM_HI 5
`define BCR_ILIM_LO 3
`define BCR_SLEW_HI 2
`define BCR_SLEW_LO 0
`define BCR_A1_RST 8'h08
`define BCR_A2_RST 8'h1A
`define BCR_B1_RST 8'h08
`define BCR_ILIM_RSVD 3'h7
`define BCR_SLEW_MIN 3'h2
`define BCR_GATE_NONE 2'h0
`define BCR_GATE_ONE 2'h1
`define BCR_GATE_TWO 2'h2
`endif

/* core/bcr_pkg.sv */
// Types shared by the converter control bank
package bcr_pkg;
    typedef enum logic [1:0] {BCR_W0, BCR_W1, BCR_LOAD, BCR_RUN} bcr_state_t;
    typedef logic [7:0] bcr_byte_t;
endpackage

/* core/bcr_top.sv */
// Converter control register bank with APB slave
// Functional notes
// [R1] Register 0 bits 5:3 show device code from configuration; bits 7:6 read zero.
// [R2] Register 1 bits 7:2 show configuration memory identification code.
// [R3] Register 1 bits 1:0 show configuration memory revision number.
// [R4] Converter A bit 4: 0 automatic mode switching, 1 forced fixed-frequency.
// [R5] Converter A bit 3 connects discharge while disabled; resets to one.
// [R6] Gating field bits 2:1: 0 bit alone, 1..3 ANDed with pin one..three.
// [R7] Converter A bit 0 enables the converter, subject to pin gating.
// [R8] Converter A bits 5:3 set peak current limit; code 7 reserved.
// [R9] Current limit code applies at once, even while running.
// [R10] Bits 2:0 set slew rate; codes 0 and 1 must not be written.
// [R11] Converter A primary control at index 2, reset value 08.
// [R12] Converter A secondary control at index 3, reset value 1A.
// [R13] Mode, enable, gating, limit and slew defaults come from configuration memory.
// [R14] Converter B primary control at index 4, reset value 08.
// [R15] Converter B control has same mode, discharge, gating, enable fields.
// [R16] Read-only writes ignored; reads return held values, reserved read-only bits zero.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "bcr_regs.svh"
module bcr_top #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // APB slave
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Configuration memory defaults
    input wire logic [2:0] CFG_DEVICE_CODE,
    input wire logic [5:0] CFG_MEMORY_CODE,
    input wire logic [1:0] CFG_MEMORY_REVISION,
    input wire bcr_pkg::bcr_byte_t CFG_A_PRIMARY,
    input wire bcr_pkg::bcr_byte_t CFG_A_SECONDARY,
    input wire bcr_pkg::bcr_byte_t CFG_B_PRIMARY,
    // External enable pins
    input wire logic EXT_ENABLE_ONE,
    input wire logic EXT_ENABLE_TWO,
    input wire logic EXT_ENABLE_THREE,
    // Converter A controls
    output logic A_FORCED_FIXED_MODE,
    output logic A_DISCHARGE_ON,
    output logic A_ENABLE,
    output logic [2:0] A_CURRENT_LIMIT,
    output logic [2:0] A_SLEW_SELECT,
    // Converter B controls
    output logic B_FORCED_FIXED_MODE,
    output logic B_DISCHARGE_ON,
    output logic B_ENABLE
);
    import bcr_pkg::*;

    // Two-flop synchronisers; only the second stage is read
    logic [37:0] s1_ff;
    logic [37:0] s2_ff;
    logic [37:0] pin_vec;
    assign pin_vec = {CFG_DEVICE_CODE, CFG_MEMORY_CODE, CFG_MEMORY_REVISION, CFG_A_PRIMARY,
        CFG_A_SECONDARY, CFG_B_PRIMARY, EXT_ENABLE_THREE, EXT_ENABLE_TWO, EXT_ENABLE_ONE};
    logic [2:0] cfg_dev;
    logic [5:0] cfg_mem;
    logic [1:0] cfg_rev;
    bcr_byte_t cfg_a1;
    bcr_byte_t cfg_a2;
    bcr_byte_t cfg_b1;
    logic [2:0] pins;
    assign {cfg_dev, cfg_mem, cfg_rev, cfg_a1, cfg_a2, cfg_b1, pins} = s2_ff;

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
        end
        else
        begin
            s1_ff <= pin_vec;
            s2_ff <= s1_ff;
        end
    end

    // Index valid when word aligned and inside the bank
    function automatic logic idx_ok(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && (a[ADDR_W-1:2] <= (ADDR_W-2)'(`BCR_IDX_B1));
    endfunction

    // Enable bit gated by the chosen pin
    function automatic logic gate_en(input bcr_byte_t c, input logic [2:0] p);
        logic g;
        g = 1'b1;
        if (c[`BCR_GATE_HI:`BCR_GATE_LO] == `BCR_GATE_ONE)
            g = p[0];
        else if (c[`BCR_GATE_HI:`BCR_GATE_LO] == `BCR_GATE_TWO)
            g = p[1];
        else if (c[`BCR_GATE_HI:`BCR_GATE_LO] != `BCR_GATE_NONE)
            g = p[2];
        return c[`BCR_EN] & g;
    endfunction

    bcr_state_t state_ff, nxt_state;
    logic [2:0] dev_ff, nxt_dev;
    logic [5:0] mem_ff, nxt_mem;
    logic [1:0] rev_ff, nxt_rev;
    bcr_byte_t a1_ff, nxt_a1;
    bcr_byte_t a2_ff, nxt_a2;
    bcr_byte_t b1_ff, nxt_b1;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [4:0] a_out_ff, nxt_a_out;
    logic [5:0] a_lim_ff, nxt_a_lim;
    logic [2:0] b_out_ff, nxt_b_out;
    logic setup;
    logic wr;
    logic [2:0] idx;
    logic a_on;
    logic b_on;
    bcr_byte_t rd;

    assign idx = PADDR[4:2];
    assign setup = PSEL && !PENABLE && (state_ff == BCR_RUN);
    assign wr = PSEL && PENABLE && pready_ff && PWRITE && !pslverr_ff;
    assign a_on = gate_en(a1_ff, pins);
    assign b_on = gate_en(b1_ff, pins);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_dev = dev_ff;
        nxt_mem = mem_ff;
        nxt_rev = rev_ff;
        nxt_a1 = a1_ff;
        nxt_a2 = a2_ff;
        nxt_b1 = b1_ff;
        rd = 8'h00;
        case (state_ff)
            BCR_W0: nxt_state = BCR_W1;
            BCR_W1: nxt_state = BCR_LOAD;
            BCR_LOAD:
            begin
                // Synchronisers are settled now; discharge keeps its fixed reset
                nxt_dev = cfg_dev; // [R1]
                nxt_mem = cfg_mem; // [R2]
                nxt_rev = cfg_rev; // [R3]
                nxt_a1 = {a1_ff[7:5], cfg_a1[`BCR_FIXED], a1_ff[`BCR_DIS], cfg_a1[2:0]}; // [R13]
                nxt_a2 = {a2_ff[7:6], cfg_a2[5:0]}; // [R13]
                nxt_b1 = {b1_ff[7:5], cfg_b1[`BCR_FIXED], b1_ff[`BCR_DIS], cfg_b1[2:0]}; // [R13]
                nxt_state = BCR_RUN;
            end
            default: nxt_state = BCR_RUN;
        endcase
        // Identification fields have no write path
        if (wr && idx == `BCR_IDX_A1) // [R11] [R16]
            nxt_a1 = PWDATA[7:0];
        else if (wr && idx == `BCR_IDX_A2) // [R12]
        begin
            nxt_a2[7:6] = PWDATA[7:6];
            // Reserved codes leave the field as it was
            if (PWDATA[`BCR_ILIM_HI:`BCR_ILIM_LO] != `BCR_ILIM_RSVD) // [R8] [R9]
                nxt_a2[5:3] = PWDATA[`BCR_ILIM_HI:`BCR_ILIM_LO];
            if (PWDATA[`BCR_SLEW_HI:`BCR_SLEW_LO] >= `BCR_SLEW_MIN) // [R10]
                nxt_a2[2:0] = PWDATA[`BCR_SLEW_HI:`BCR_SLEW_LO];
        end
        else if (wr && idx == `BCR_IDX_B1) // [R14] [R15]
            nxt_b1 = PWDATA[7:0];
        if (idx == `BCR_IDX_DEV)
            rd = {2'h0, dev_ff, 3'h0}; // [R1]
        else if (idx == `BCR_IDX_MEM)
            rd = {mem_ff, rev_ff}; // [R2] [R3]
        else if (idx == `BCR_IDX_A1)
            rd = a1_ff; // [R16]
        else if (idx == `BCR_IDX_A2)
            rd = a2_ff;
        else if (idx == `BCR_IDX_B1)
            rd = b1_ff;
        // One wait-free access phase per transfer
        nxt_pready = setup;
        nxt_pslverr = setup && !idx_ok(PADDR);
        nxt_prdata = 32'h0000_0000;
        if (setup && !PWRITE && idx_ok(PADDR))
            nxt_prdata = {24'h00_0000, rd};
        // Outputs lag the register by one cycle
        nxt_a_out = {a1_ff[`BCR_FIXED], a1_ff[`BCR_DIS] & !a_on, a_on, 2'h0}; // [R4] [R5] [R6] [R7]
        nxt_a_lim = a2_ff[5:0]; // [R8] [R9] [R10]
        nxt_b_out = {b1_ff[`BCR_FIXED], b1_ff[`BCR_DIS] & !b_on, b_on}; // [R15]
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_ff <= BCR_W0;
            dev_ff <= 3'h0;
            mem_ff <= 6'h00;
            rev_ff <= 2'h0;
            a1_ff <= `BCR_A1_RST; // [R11]
            a2_ff <= `BCR_A2_RST; // [R12]
            b1_ff <= `BCR_B1_RST; // [R14]
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            a_out_ff <= 5'h00;
            a_lim_ff <= 6'h00;
            b_out_ff <= 3'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            dev_ff <= nxt_dev;
            mem_ff <= nxt_mem;
            rev_ff <= nxt_rev;
            a1_ff <= nxt_a1;
            a2_ff <= nxt_a2;
            b1_ff <= nxt_b1;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            a_out_ff <= nxt_a_out;
            a_lim_ff <= nxt_a_lim;
            b_out_ff <= nxt_b_out;
        end
    end

    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign A_FORCED_FIXED_MODE = a_out_ff[4];
    assign A_DISCHARGE_ON = a_out_ff[3];
    assign A_ENABLE = a_out_ff[2];
    assign A_CURRENT_LIMIT = a_lim_ff[5:3];
    assign A_SLEW_SELECT = a_lim_ff[2:0];
    assign B_FORCED_FIXED_MODE = b_out_ff[2];
    assign B_DISCHARGE_ON = b_out_ff[1];
    assign B_ENABLE = b_out_ff[0];

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    logic rd_setup;
    assign rd_setup = setup && !PWRITE;

    dev_id_read_a: assert property (rd_setup && PADDR == 8'h00 |=> // [R1]
        PRDATA == {24'h0, 2'h0, $past(dev_ff), 3'h0})
        else $error("device code read wrong");
    mem_code_read_a: assert property (rd_setup && PADDR == 8'h04 |=> // [R2]
        PRDATA[7:2] == $past(mem_ff))
        else $error("memory code read wrong");
    mem_rev_read_a: assert property (rd_setup && PADDR == 8'h04 |=> // [R3]
        PRDATA[1:0] == $past(rev_ff) && PREADY)
        else $error("memory revision read wrong");
    fixed_mode_a: assert property (state_ff == BCR_RUN |=> // [R4]
        A_FORCED_FIXED_MODE == $past(a1_ff[4]))
        else $error("forced mode output wrong");
    discharge_out_a: assert property (state_ff == BCR_RUN && a1_ff[3] |=> // [R5]
        A_DISCHARGE_ON != A_ENABLE)
        else $error("discharge not opposite to enable");
    enable_gate_a: assert property (a1_ff[2:1] == 2'h2 && !pins[1] |=> !A_ENABLE) // [R6]
        else $error("pin gating ignored");
    enable_bit_a: assert property (!a1_ff[0] |=> !A_ENABLE ##0 B_ENABLE == $past(b_on)) // [R7]
        else $error("enable bit ignored");
    ilim_live_a: assert property (wr && PADDR == 8'h0C && PWDATA[5:3] != 3'h7 |=> // [R9]
        ##1 A_CURRENT_LIMIT == $past(PWDATA[5:3], 2))
        else $error("current limit not applied");
    ilim_rsvd_a: assert property (wr && PWDATA[5:3] == 3'h7 |=> a2_ff[5:3] != 3'h7) // [R8]
        else $error("reserved limit stored");
    slew_rsvd_a: assert property (wr && PADDR == 8'h0C && PWDATA[2:0] < 3'h2 |=> // [R10]
        $stable(a2_ff[2:0]))
        else $error("reserved slew stored");
    reset_vals_a: assert property (state_ff == BCR_W0 |-> // [R11]
        a1_ff == 8'h08 && a2_ff == 8'h1A && b1_ff == 8'h08)
        else $error("reset values wrong");
    cfg_load_a: assert property (state_ff == BCR_LOAD |=> // [R13]
        a2_ff[5:0] == $past(cfg_a2[5:0]) && a1_ff[3] == $past(a1_ff[3]))
        else $error("configuration defaults not loaded");
    ro_write_a: assert property (wr && PADDR == 8'h00 |=> $stable(dev_ff) ##0 $stable(mem_ff)) // [R16]
        else $error("read-only field written");
    a1_write_a: assert property (wr && idx == `BCR_IDX_A1 |=> // [R11]
        a1_ff == $past(PWDATA[7:0]))
        else $error("primary control write lost");
    bad_addr_a: assert property (setup && !idx_ok(PADDR) |=> // [R16]
        PSLVERR && PREADY && PRDATA == 32'h0)
        else $error("bad address not refused");
    b_gate_a: assert property (b1_ff[2:1] == 2'h1 && !pins[0] |=> !B_ENABLE) // [R15]
        else $error("converter b pin gating ignored");

    write_a2_c: cover property (wr && PADDR == 8'h0C);
    read_id_c: cover property (rd_setup && PADDR == 8'h00);
    gated_on_c: cover property (a1_ff[2:1] != 2'h0 && A_ENABLE);
    error_c: cover property (PSLVERR);
    live_limit_c: cover property (wr && idx == `BCR_IDX_A2 && A_ENABLE);
endmodule // bcr_top
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the converter control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bcr_pkg::*;
    typedef struct packed
    {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
        logic err;
    } bcr_row_t;
    logic CLK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, er, A_FORCED_FIXED_MODE, A_DISCHARGE_ON, A_ENABLE;
    logic B_FORCED_FIXED_MODE, B_DISCHARGE_ON, B_ENABLE;
    logic [2:0] A_CURRENT_LIMIT, A_SLEW_SELECT, pins = 3'h7;
    bcr_byte_t cfg_sec = 8'h23;
    int failures = 0, total_checks = 0;
    bcr_row_t rows [17];
    always #25 CLK = ~CLK;
    // Identity values below are arbitrary
    bcr_top u_bcr_top (.CLK(CLK), .RSTN(RSTN), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .CFG_DEVICE_CODE(3'h5), .CFG_MEMORY_CODE(6'h2B), .CFG_MEMORY_REVISION(2'h1),
        .CFG_A_PRIMARY(8'hF2), .CFG_A_SECONDARY(cfg_sec), .CFG_B_PRIMARY(8'h05),
        .EXT_ENABLE_ONE(pins[0]), .EXT_ENABLE_TWO(pins[1]), .EXT_ENABLE_THREE(pins[2]),
        .A_FORCED_FIXED_MODE(A_FORCED_FIXED_MODE), .A_DISCHARGE_ON(A_DISCHARGE_ON),
        .A_ENABLE(A_ENABLE), .A_CURRENT_LIMIT(A_CURRENT_LIMIT), .A_SLEW_SELECT(A_SLEW_SELECT),
        .B_FORCED_FIXED_MODE(B_FORCED_FIXED_MODE), .B_DISCHARGE_ON(B_DISCHARGE_ON),
        .B_ENABLE(B_ENABLE));
    task summarize;
        $display("Checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One transfer; request held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= {24'h0, wd};
        @(posedge CLK);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1)
        begin
            failures++;
            $display("ERROR pready expected 1 seen %b", PREADY);
            summarize();
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // Write a control byte, pick pin levels, then look at the converter that was written
    task gate(input logic [7:0] idx, input logic [7:0] v, input logic [2:0] p, input logic en);
        apb(1'b1, idx, v);
        pins <= p;
        repeat (6) @(posedge CLK);
        if (idx == 8'h08)
        begin
            chk("a_enable", {31'h0, en}, {31'h0, A_ENABLE});
            chk("a_discharge", {31'h0, !en & v[3]}, {31'h0, A_DISCHARGE_ON});
            chk("a_forced", {31'h0, v[4]}, {31'h0, A_FORCED_FIXED_MODE});
        end
        else
        begin
            chk("b_enable", {31'h0, en}, {31'h0, B_ENABLE});
            chk("b_discharge", {31'h0, !en & v[3]}, {31'h0, B_DISCHARGE_ON});
            chk("b_forced", {31'h0, v[4]}, {31'h0, B_FORCED_FIXED_MODE});
        end
    endtask
    initial
    begin
        rows = '{
            '{1'b0, 8'h00, 8'h00, 8'h28, 1'b0},
            '{1'b0, 8'h04, 8'h00, 8'hAD, 1'b0},
            '{1'b0, 8'h08, 8'h00, 8'h1A, 1'b0},
            '{1'b0, 8'h0C, 8'h00, 8'h23, 1'b0},
            '{1'b0, 8'h10, 8'h00, 8'h0D, 1'b0},
            '{1'b1, 8'h00, 8'hFF, 8'h00, 1'b0},
            '{1'b0, 8'h00, 8'h00, 8'h28, 1'b0},
            '{1'b1, 8'h04, 8'h00, 8'h00, 1'b0},
            '{1'b0, 8'h04, 8'h00, 8'hAD, 1'b0},
            '{1'b1, 8'h08, 8'hE9, 8'h00, 1'b0},
            '{1'b0, 8'h08, 8'h00, 8'hE9, 1'b0},
            '{1'b1, 8'h0C, 8'hC7, 8'h00, 1'b0},
            '{1'b0, 8'h0C, 8'h00, 8'hC7, 1'b0},
            '{1'b1, 8'h0C, 8'h39, 8'h00, 1'b0},
            '{1'b0, 8'h0C, 8'h00, 8'h07, 1'b0},
            '{1'b0, 8'h14, 8'h00, 8'h00, 1'b1},
            '{1'b0, 8'h09, 8'h00, 8'h00, 1'b1}};
        repeat (16) @(posedge CLK);
        chk("discharge in reset", 32'h0, {31'h0, A_DISCHARGE_ON});
        RSTN <= 1'b1;
        repeat (6) @(posedge CLK);
        for (int i = 0; i < 17; i++)
        begin
            apb(rows[i].wr, rows[i].addr, rows[i].data);
            chk("pslverr", {31'h0, rows[i].err}, {31'h0, er});
            if (!rows[i].wr)
                chk("prdata", {24'h0, rows[i].exp}, rd);
        end
        $display("Register table test done");
        repeat (2) @(posedge CLK);
        chk("limit", 32'h0, {29'h0, A_CURRENT_LIMIT});
        chk("slew", 32'h7, {29'h0, A_SLEW_SELECT});
        // Chosen pin alone low, then alone high: a wrong pin choice shows up
        for (int g = 0; g < 4; g++)
        begin
            logic [2:0] sel;
            sel = 3'h0;
            if (g != 0)
                sel = 3'h1 << (g - 1);
            gate(8'h08, {3'h0, g[0], 1'b1, g[1:0], 1'b1}, ~sel, g == 0);
            gate(8'h08, {3'h0, g[0], 1'b1, g[1:0], 1'b1}, sel, 1'b1);
            gate(8'h10, {3'h0, g[0], 1'b1, g[1:0], 1'b1}, ~sel, g == 0);
        end
        gate(8'h08, 8'h08, 3'h7, 1'b0);
        gate(8'h08, 8'h00, 3'h7, 1'b0);
        gate(8'h08, 8'h01, 3'h7, 1'b1);
        $display("Gating test done");
        apb(1'b1, 8'h0C, 8'h2A);
        repeat (2) @(posedge CLK);
        chk("limit running", 32'h5, {29'h0, A_CURRENT_LIMIT});
        chk("slew running", 32'h2, {29'h0, A_SLEW_SELECT});
        chk("still running", 32'h1, {31'h0, A_ENABLE});
        $display("Live update test done");
        // New defaults must be picked up on the next reset only
        @(posedge CLK);
        cfg_sec <= 8'hD4;
        RSTN <= 1'b0;
        @(posedge CLK);
        chk("enable in reset", 32'h0, {31'h0, A_ENABLE});
        RSTN <= 1'b1;
        repeat (6) @(posedge CLK);
        apb(1'b0, 8'h0C, 8'h00);
        chk("reloaded limit", 32'h14, rd);
        apb(1'b0, 8'h08, 8'h00);
        chk("reloaded control", 32'h1A, rd);
        $display("Second reset test done");
        summarize();
    end
endmodule // testbench
`default_nettype wire
